//--- src/cps_alu.sv
`timescale 1ns/1ns
// ==========================================================================
// Eight-bit arithmetic and logic unit.
// ==========================================================================
module cps_alu
   import cps_pkg::*;
(
   // Operation and operands.
   input wire cps_alu_fn_t func_i,
   input wire logic [DATA_W-1:0] a_i,
   input wire logic [DATA_W-1:0] b_i,
   input wire cps_flags_t flags_i,
   // Result and updated flags.
   output logic [DATA_W-1:0] result_o,
   output cps_flags_t flags_o
);

   // ======================================================================
   // Shared adder: subtraction adds the complement, so carry means no borrow.
   // ======================================================================
   wire sub_sel = (func_i == ALU_SUB) || (func_i == ALU_SBC);
   wire [DATA_W-1:0] addend = sub_sel ? ~b_i : b_i;
   wire cin = (func_i == ALU_ADD) ? 1'b0 : ((func_i == ALU_SUB) ? 1'b1 : flags_i.c);
   wire [8:0] sum = {1'b0, a_i} + {1'b0, addend} + {8'h00, cin};
   wire [4:0] nib = {1'b0, a_i[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
   wire add_ov = (a_i[7] == addend[7]) && (sum[7] != a_i[7]);

   // Decimal adjust works in two steps so the high fix sees the low carry.
   wire lo_fix = (a_i[3:0] > 4'h9) || flags_i.ac;
   wire [8:0] daa_step = {1'b0, a_i} + (lo_fix ? 9'h006 : 9'h000);
   wire hi_fix = (daa_step[7:4] > 4'h9) || flags_i.c || daa_step[8];
   wire [8:0] daa_sum = daa_step + (hi_fix ? 9'h060 : 9'h000);

   // ======================================================================
   // Result select and flag update.
   // ======================================================================
   // [RL18] Result and flag update.
   // [RL19] Operation groups.
   always_comb begin
      result_o = a_i;
      flags_o = flags_i;
      case (func_i)
         ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC: begin
            result_o = sum[7:0];
            flags_o.c = sum[8];
            flags_o.ac = nib[4];
            flags_o.ov = add_ov;
         end
         ALU_DAA: begin
            result_o = daa_sum[7:0];
            flags_o.c = hi_fix;
         end
         ALU_AND: result_o = a_i & b_i;
         ALU_OR: result_o = a_i | b_i;
         ALU_XOR: result_o = a_i ^ b_i;
         ALU_CPL: result_o = ~a_i;
         ALU_RR: result_o = {a_i[0], a_i[7:1]};
         ALU_RRC: begin
            result_o = {flags_i.c, a_i[7:1]};
            flags_o.c = a_i[0];
         end
         ALU_RL: result_o = {a_i[6:0], a_i[7]};
         ALU_RLC: begin
            result_o = {a_i[6:0], flags_i.c};
            flags_o.c = a_i[7];
         end
         ALU_INC: result_o = a_i + 8'h01;
         ALU_DEC: result_o = a_i - 8'h01;
         default: result_o = b_i;
      endcase
      flags_o.z = (result_o == 8'h00);
   end

endmodule : cps_alu

//--- src/cps_pkg.sv
// ==========================================================================
// Shared constants and types for the instruction sequencer.
// ==========================================================================
package cps_pkg;

   // ======================================================================
   // Widths and sizes.
   // ======================================================================
   localparam int unsigned PC_W = 12;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned INSN_W = 15;
   localparam int unsigned PMEM_WORDS = 4096;
   localparam int unsigned STACK_LEVELS = 6;
   localparam int unsigned SP_W = 3;
   localparam int unsigned APB_ADDR_W = 12;
   localparam logic [SP_W-1:0] STACK_FULL_CNT = 3'h6;
   localparam logic [SP_W-1:0] SP_LAST = 3'h5;

   // ======================================================================
   // Vectors and reset values.
   // ======================================================================
   localparam logic [PC_W-1:0] RESET_VECTOR = 12'h000;
   localparam logic [PC_W-1:0] IRQ_VECTOR = 12'h004;
   localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
   localparam logic [SP_W-1:0] SP_RESET = 3'h0;

   // ======================================================================
   // Register offsets and field positions.
   // ======================================================================
   localparam logic [APB_ADDR_W-1:0] OFS_PC_LOW = 12'h000;
   localparam logic [APB_ADDR_W-1:0] OFS_CTRL = 12'h004;
   localparam logic [APB_ADDR_W-1:0] OFS_STATUS = 12'h008;
   localparam logic [APB_ADDR_W-1:0] OFS_ACC = 12'h00c;
   localparam int unsigned CTRL_IRQ_EN_BIT = 0;
   localparam int unsigned STAT_FLAGS_LSB = 0;
   localparam int unsigned STAT_DEPTH_LSB = 4;
   localparam int unsigned STAT_PEND_BIT = 7;
   localparam int unsigned STAT_PC_HIGH_LSB = 8;
   localparam int unsigned STAT_IRQ_EN_BIT = 12;

   // ======================================================================
   // Instruction word layout and operation codes.
   // ======================================================================
   typedef enum logic [2:0] {
      OP_ALU = 3'h0,
      OP_UNCONDITIONAL_BRANCH = 3'h1,
      OP_CALL = 3'h2,
      OP_ROUTINE_EXIT = 3'h3,
      OP_INTERRUPT_EXIT = 3'h4,
      OP_SKIP_ZERO = 3'h5,
      OP_SKIP_NONZERO = 3'h6,
      OP_WRITE_PC_LOW = 3'h7
   } cps_op_t;

   typedef struct packed {
      cps_op_t op;
      logic [PC_W-1:0] arg;
   } cps_insn_t;

   typedef enum logic [3:0] {
      ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_DAA, ALU_AND, ALU_OR, ALU_XOR,
      ALU_CPL, ALU_RR, ALU_RRC, ALU_RL, ALU_RLC, ALU_INC, ALU_DEC, ALU_PASS
   } cps_alu_fn_t;

   typedef struct packed {
      logic ov;
      logic z;
      logic ac;
      logic c;
   } cps_flags_t;

   typedef enum logic [1:0] {PH_T1, PH_T2, PH_T3, PH_T4} cps_phase_t;

endpackage : cps_pkg

//--- src/cps_sequencer.sv
`timescale 1ns/1ns
// Behaviour
// [RL1] Four phases form one instruction cycle.
// [RL2] Counter increments and fetch in first phase.
// [RL3] Decode and execute in phases two to four.
// [RL4] Fetch overlaps execution, one per cycle.
// [RL5] Branches take two instruction cycles.
// [RL6] Non-branch advances counter by one.
// [RL7] Jump, call, interrupt, reset load target.
// [RL8] Taken skip discards prefetch, dummy cycle.
// [RL9] Twelve-bit counter, only low byte visible; the status word also shows the high four bits.
// [RL10] Low byte write jumps within page.
// [RL11] Low byte write adds dummy cycle.
// [RL12] Six-level hidden stack of counter values.
// [RL13] Call or acknowledge pushes counter.
// [RL14] Returns pop and restore counter.
// [RL15] Reset points stack at top.
// [RL16] Full stack defers interrupt, keeps request.
// [RL17] Call on full stack loses oldest.
// [RL18] ALU updates flags, writes result register.
// [RL19] ALU supports arithmetic, logic, rotate, branch groups.
// [RL20] Fetch starts at address zero.
// [RL21] Program memory is 4K fifteen-bit words.
// [RL22] Deferred interrupt taken once level frees.
// [RL23] Wrapping stack index overwrites oldest entry.
module cps_sequencer
   import cps_pkg::*;
(
   // Clock and reset.
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   // APB register slave.
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [APB_ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Program memory fetch port.
   output logic [PC_W-1:0] pmem_addr_o,
   output logic pmem_rd_o,
   input wire logic [INSN_W-1:0] pmem_data_i,
   // Interrupt request and acknowledge.
   input wire logic irq_req_i,
   output logic irq_ack_o,
   // Phase clocks, one-hot.
   output logic [3:0] phase_o
);

   // ======================================================================
   // State.
   // ======================================================================
   cps_phase_t phase_reg;
   cps_phase_t phase_next;
   logic [3:0] phase_oh_reg;
   logic [PC_W-1:0] pc_reg;
   logic [PC_W-1:0] pc_next;
   cps_insn_t fetch_reg;
   cps_insn_t ir_reg;
   logic ir_valid_reg;
   logic [DATA_W-1:0] acc_reg;
   cps_flags_t flags_reg;
   logic [PC_W-1:0] stack_mem [STACK_LEVELS];
   logic [SP_W-1:0] sp_reg;
   logic [SP_W-1:0] depth_reg;
   logic irq_pend_reg;
   logic irq_en_reg;
   logic irq_ack_reg;
   logic pcl_wr_pend_reg;
   logic [DATA_W-1:0] pcl_wr_data_reg;
   logic [31:0] prdata_reg;
   logic pslverr_reg;

   // Wrapping stack index helpers.
   function automatic logic [SP_W-1:0] sp_inc(input logic [SP_W-1:0] x);
      sp_inc = (x == SP_LAST) ? SP_RESET : x + 3'h1;
   endfunction : sp_inc

   function automatic logic [SP_W-1:0] sp_dec(input logic [SP_W-1:0] x);
      sp_dec = (x == SP_RESET) ? SP_LAST : x - 3'h1;
   endfunction : sp_dec

   // ======================================================================
   // Decode of the executing instruction.
   // ======================================================================
   // [RL3] Decode across the execute phases.
   wire boundary = (phase_reg == PH_T4);
   wire exec = boundary && ir_valid_reg;
   wire is_branch = exec && (ir_reg.op == OP_UNCONDITIONAL_BRANCH);
   wire is_call = exec && (ir_reg.op == OP_CALL);
   wire is_rtn = exec && (ir_reg.op == OP_ROUTINE_EXIT);
   wire is_rti = exec && (ir_reg.op == OP_INTERRUPT_EXIT);
   wire is_wpcl = exec && (ir_reg.op == OP_WRITE_PC_LOW);
   wire is_alu = exec && (ir_reg.op == OP_ALU);
   wire is_skz = exec && (ir_reg.op == OP_SKIP_ZERO);
   wire is_sknz = exec && (ir_reg.op == OP_SKIP_NONZERO);
   wire is_pop = is_rtn || is_rti;
   wire flow_insn = is_branch || is_call || is_pop || is_wpcl;

   // ======================================================================
   // ALU.
   // ======================================================================
   logic [DATA_W-1:0] alu_result;
   cps_flags_t alu_flags;
   wire cps_alu_fn_t alu_func = cps_alu_fn_t'(ir_reg.arg[11:8]);

   cps_alu u_alu (
      .func_i(alu_func),
      .a_i(acc_reg),
      .b_i(ir_reg.arg[7:0]),
      .flags_i(flags_reg),
      .result_o(alu_result),
      .flags_o(alu_flags)
   );

   // Skip ops write back only for increment and decrement forms.
   wire skip_wb = (is_skz || is_sknz) && ((alu_func == ALU_INC) || (alu_func == ALU_DEC));
   // [RL19] Branch condition evaluation.
   wire skip_taken = (is_skz && alu_flags.z) || (is_sknz && !alu_flags.z);

   // ======================================================================
   // Redirect and interrupt arbitration at the instruction boundary.
   // ======================================================================
   wire stack_full = (depth_reg == STACK_FULL_CNT);
   // [RL10] Bus write branches at the first boundary that carries no flow instruction.
   wire take_apb_pcl = boundary && pcl_wr_pend_reg && !flow_insn;
   // [RL16] Full stack withholds acknowledge.
   // [RL22] Deferred request taken at a free boundary.
   wire irq_ack = boundary && irq_pend_reg && irq_en_reg && !stack_full && !flow_insn
      && !take_apb_pcl && !skip_taken;
   wire redirect = flow_insn || take_apb_pcl || skip_taken || irq_ack;
   // [RL13] Call or acknowledge pushes.
   wire do_push = is_call || irq_ack;
   // The instruction waiting in the fetch register sits one below the counter.
   wire [PC_W-1:0] ret_addr = pc_reg - 12'h001;
   wire [PC_W-1:0] stack_top = stack_mem[sp_dec(sp_reg)];

   // Redirect target select.
   // [RL6] Sequential advance by one.
   // [RL7] Load the required target.
   // [RL14] Return restores saved counter.
   // [RL10] Page bits kept on low byte write.
   always_comb begin
      pc_next = pc_reg;
      if (phase_reg == PH_T1) begin
         pc_next = pc_reg + 12'h001;
      end else if (boundary) begin
         if (is_branch || is_call) begin
            pc_next = ir_reg.arg;
         end else if (is_pop) begin
            pc_next = stack_top;
         end else if (is_wpcl) begin
            pc_next = {pc_reg[PC_W-1:DATA_W], acc_reg};
         end else if (take_apb_pcl) begin
            pc_next = {pc_reg[PC_W-1:DATA_W], pcl_wr_data_reg};
         end else if (irq_ack) begin
            pc_next = IRQ_VECTOR;
         end
      end
   end

   // [RL1] Phase sequence T1 to T4.
   always_comb begin
      case (phase_reg)
         PH_T1: phase_next = PH_T2;
         PH_T2: phase_next = PH_T3;
         PH_T3: phase_next = PH_T4;
         PH_T4: phase_next = PH_T1;
         default: phase_next = PH_T1;
      endcase
   end

   // ======================================================================
   // Phase, counter and pipeline registers.
   // ======================================================================
   // [RL20] Reset starts at address zero.
   // [RL2] Increment and fetch in T1.
   // [RL4] Overlapped fetch and execute.
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         phase_reg <= PH_T1;
         phase_oh_reg <= 4'h1;
         pc_reg <= RESET_VECTOR;
         fetch_reg <= '0;
         ir_reg <= '0;
         ir_valid_reg <= 1'b0;
      end else begin
         phase_reg <= phase_next;
         phase_oh_reg <= 4'h1 << phase_next;
         pc_reg <= pc_next;
         if (phase_reg == PH_T1) begin
            fetch_reg <= cps_insn_t'(pmem_data_i);
         end
         // [RL5] Branches spend a dummy cycle.
         // [RL8] Redirects turn the next cycle into a dummy.
         // [RL11] Low byte writes insert a dummy.
         if (boundary) begin
            ir_reg <= fetch_reg;
            ir_valid_reg <= !redirect;
         end
      end
   end

   // Accumulator and status flags.
   // [RL18] Result to accumulator.
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         acc_reg <= ACC_RESET;
         flags_reg <= '0;
      end else if (is_alu) begin
         acc_reg <= alu_result;
         flags_reg <= alu_flags;
      end else if (skip_wb) begin
         acc_reg <= alu_result;
      end
   end

   // ======================================================================
   // Return stack; the index wraps, so an overflowing push eats the oldest.
   // ======================================================================
   // [RL12] Hidden six-level stack.
   // [RL23] Wrapping index overwrite.
   always_ff @(posedge clk_sys_i) begin
      if (do_push) begin
         stack_mem[sp_reg] <= ret_addr;
      end
   end

   // [RL15] Reset points at the top.
   // [RL17] Call on a full stack proceeds.
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         sp_reg <= SP_RESET;
         depth_reg <= SP_RESET;
      end else if (do_push) begin
         sp_reg <= sp_inc(sp_reg);
         depth_reg <= stack_full ? depth_reg : depth_reg + 3'h1;
      end else if (is_pop) begin
         sp_reg <= sp_dec(sp_reg);
         depth_reg <= (depth_reg == SP_RESET) ? depth_reg : depth_reg - 3'h1;
      end
   end

   // ======================================================================
   // Interrupt request and enable; a new request beats the clear.
   // ======================================================================
   wire apb_write = psel_i && penable_i && pwrite_i && pstrb_i[0];
   wire apb_setup = psel_i && !penable_i;
   wire hit_pcl = (paddr_i == OFS_PC_LOW);
   wire hit_ctrl = (paddr_i == OFS_CTRL);
   wire hit_status = (paddr_i == OFS_STATUS);
   wire hit_acc = (paddr_i == OFS_ACC);
   wire hit_any = hit_pcl || hit_ctrl || hit_status || hit_acc;

   // [RL16] Request flag recorded regardless of stack state.
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         irq_pend_reg <= 1'b0;
         irq_en_reg <= 1'b0;
         irq_ack_reg <= 1'b0;
      end else begin
         irq_pend_reg <= irq_req_i || (irq_pend_reg && !irq_ack);
         irq_ack_reg <= irq_ack;
         if (irq_ack) begin
            irq_en_reg <= 1'b0;
         end else if (is_rti) begin
            irq_en_reg <= 1'b1;
         end else if (apb_write && hit_ctrl) begin
            irq_en_reg <= pwdata_i[CTRL_IRQ_EN_BIT];
         end
      end
   end

   // ======================================================================
   // APB slave: zero wait states, read data captured in the setup cycle.
   // ======================================================================
   wire [31:0] status_word = {19'h00000, irq_en_reg, pc_reg[PC_W-1:DATA_W], irq_pend_reg,
      depth_reg, flags_reg};
   // [RL9] Low counter byte reads at OFS_PC_LOW; the status word also shows the high four bits.
   wire [31:0] read_mux = hit_pcl ? {24'h000000, pc_reg[DATA_W-1:0]} :
      hit_ctrl ? {31'h00000000, irq_en_reg} :
      hit_status ? status_word :
      hit_acc ? {24'h000000, acc_reg} : 32'h00000000;

   // A later bus write replaces the pending target; set beats clear.
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         pcl_wr_pend_reg <= 1'b0;
         pcl_wr_data_reg <= 8'h00;
         prdata_reg <= 32'h00000000;
         pslverr_reg <= 1'b0;
      end else begin
         if (apb_write && hit_pcl) begin
            pcl_wr_pend_reg <= 1'b1;
            pcl_wr_data_reg <= pwdata_i[DATA_W-1:0];
         end else if (take_apb_pcl) begin
            pcl_wr_pend_reg <= 1'b0;
         end
         if (apb_setup) begin
            prdata_reg <= pwrite_i ? 32'h00000000 : read_mux;
            pslverr_reg <= !hit_any;
         end
      end
   end

   // ======================================================================
   // Outputs.
   // ======================================================================
   assign prdata_o = prdata_reg;
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i && penable_i && pslverr_reg;
   // [RL21] Fetch address and strobe to 4K-word memory.
   assign pmem_addr_o = pc_reg;
   assign pmem_rd_o = phase_oh_reg[0];
   assign irq_ack_o = irq_ack_reg;
   assign phase_o = phase_oh_reg;

   // ======================================================================
   // Assertions.
   // ======================================================================
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);

   chk_phase_order: assert property (boundary |=> phase_reg == PH_T1) // [RL1]
      else $error("phase did not wrap to T1");
   chk_pc_incr: assert property ((phase_reg == PH_T1) // [RL2]
      |=> pc_reg == $past(pc_reg) + 12'h001)
      else $error("counter not incremented in T1");
   chk_fetch_take: assert property ((phase_reg == PH_T1) ##1 1'b1 [*2] ##1 !redirect // [RL4]
      |=> ir_reg == $past(fetch_reg) && ir_valid_reg)
      else $error("fetched word not passed to execute");
   chk_seq_advance: assert property (boundary && !redirect // [RL6]
      |=> ##3 pc_reg == $past(pc_reg, 4) + 12'h001)
      else $error("sequential counter advance wrong");
   chk_branch_dummy: assert property (boundary && redirect |=> !ir_valid_reg [*4]) // [RL5]
      else $error("no dummy cycle after redirect");
   chk_jump_target: assert property (is_branch |=> pc_reg == $past(ir_reg.arg)) // [RL7]
      else $error("jump target not loaded");
   chk_pcl_page: assert property (take_apb_pcl // [RL10]
      |=> pc_reg == {$past(pc_reg[11:8]), $past(pcl_wr_data_reg)})
      else $error("low byte write left page");
   chk_push_depth: assert property (do_push && !stack_full // [RL13]
      |=> depth_reg == $past(depth_reg) + 3'h1)
      else $error("push did not deepen stack");
   chk_irq_hold: assert property (stack_full |-> !irq_ack) // [RL16]
      else $error("interrupt acknowledged on full stack");
   chk_overflow_full: assert property (do_push && stack_full |=> stack_full) // [RL17]
      else $error("overflow changed depth");
   chk_reset_top: assert property (@(posedge clk_sys_i) disable iff (1'b0) // [RL15]
      sys_rst_i |=> sp_reg == SP_RESET && depth_reg == SP_RESET && pc_reg == RESET_VECTOR)
      else $error("reset did not restore top of stack");

   cov_call: cover property (is_call ##[1:40] is_rtn);
   cov_irq_ack: cover property (irq_ack);
   cov_skip: cover property (skip_taken);
   cov_overflow: cover property (do_push && stack_full);

endmodule : cps_sequencer

//--- tb/cps_pmem_model.sv
`timescale 1ns/1ns
// ======================================================================
// Program memory that answers a fetch in the same cycle.
// ======================================================================
module cps_pmem_model
   import cps_pkg::*;
(
   // Clock.
   input wire logic clk_sys_i,
   // Fetch port.
   input wire logic [PC_W-1:0] pmem_addr_i,
   input wire logic pmem_rd_i,
   output logic [INSN_W-1:0] pmem_data_o
);
   logic [INSN_W-1:0] mem [PMEM_WORDS];
   logic [INSN_W-1:0] last_word;
   // Outside a fetch the bus shows the inverse word, so stale data is never mistaken for good.
   assign pmem_data_o = pmem_rd_i ? mem[pmem_addr_i] : ~last_word;
   // Remember the word handed out last.
   always @(posedge clk_sys_i) begin
      if (pmem_rd_i) begin
         last_word <= mem[pmem_addr_i];
      end
   end
   // Test program: call, return, branch, skip, low-byte jump, then a six-deep call chain.
   initial begin
      last_word = '0;
      for (int i = 0; i < PMEM_WORDS; i++) begin
         mem[i] = {OP_ALU, 12'hf00};
      end
      mem[0] = {OP_ALU, 12'hf05};
      mem[1] = {OP_CALL, 12'h010};
      mem[2] = {OP_UNCONDITIONAL_BRANCH, 12'h020};
      mem[4] = {OP_INTERRUPT_EXIT, 12'h000};
      mem[16] = {OP_ROUTINE_EXIT, 12'h000};
      mem[32] = {OP_SKIP_ZERO, 12'hf00};
      mem[33] = {OP_UNCONDITIONAL_BRANCH, 12'h0ff};
      // Adding 0x3b to 0x05 gives 0x40 and sets only the half carry.
      mem[34] = {OP_ALU, 12'h03b};
      mem[35] = {OP_WRITE_PC_LOW, 12'h000};
      mem[64] = {OP_UNCONDITIONAL_BRANCH, 12'h040};
      for (int i = 0; i < 6; i++) begin
         mem[96 + i] = {OP_CALL, 12'(97 + i)};
      end
      mem[102] = {OP_UNCONDITIONAL_BRANCH, 12'h066};
      mem[103] = {OP_ROUTINE_EXIT, 12'h000};
   end
endmodule : cps_pmem_model

//--- tb/cps_sequencer_tb.sv
`timescale 1ns/1ns
// ======================================================================
// Self-checking bench for the instruction sequencer.
// ======================================================================
module cps_sequencer_tb
   import cps_pkg::*;
;
   logic clk_sys_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic irq_req_i = 1'b0;
   logic [APB_ADDR_W-1:0] paddr_i = '0;
   logic [31:0] pwdata_i = '0;
   logic [3:0] pstrb_i = '0;
   logic [31:0] prdata_o;
   logic pready_o, pslverr_o, pmem_rd_o, irq_ack_o, err;
   logic [PC_W-1:0] pmem_addr_o;
   logic [INSN_W-1:0] pmem_data_i;
   logic [3:0] phase_o, ph;
   logic [31:0] rd;
   logic [PC_W-1:0] trace [$];
   logic [PC_W-1:0] exp_tr [16] = '{12'h0, 12'h1, 12'h2, 12'h10, 12'h11, 12'h2, 12'h3,
      12'h20, 12'h21, 12'h22, 12'h23, 12'h24, 12'h40, 12'h41, 12'h40, 12'h41};
   int num_errors = 0;
   int num_checks = 0;
   int acks = 0;
   int n;

   // Free-running 250 MHz clock.
   always #2 clk_sys_i = ~clk_sys_i;

   cps_sequencer dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .pmem_addr_o(pmem_addr_o), .pmem_rd_o(pmem_rd_o), .pmem_data_i(pmem_data_i),
      .irq_req_i(irq_req_i), .irq_ack_o(irq_ack_o), .phase_o(phase_o));
   cps_pmem_model pmem (.clk_sys_i(clk_sys_i), .pmem_addr_i(pmem_addr_o),
      .pmem_rd_i(pmem_rd_o), .pmem_data_o(pmem_data_i));

   // Log fetch addresses and acknowledge pulses as sampled at each edge.
   always @(posedge clk_sys_i) begin
      if (!sys_rst_i && pmem_rd_o) trace.push_back(pmem_addr_o);
      if (!sys_rst_i && irq_ack_o) acks++;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask : chk

   // One APB transfer; the request holds until pready is seen high.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      pstrb_i <= 4'hf;
      @(posedge clk_sys_i);
      penable_i <= 1'b1;
      do @(posedge clk_sys_i); while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb

   task automatic t_reset();
      repeat (10) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      #1;
      chk(pmem_addr_o, RESET_VECTOR, "fetch after reset");
      chk(phase_o, 4'h1, "phase after reset");
      for (int i = 0; i < 8; i++) begin
         ph = phase_o;
         @(posedge clk_sys_i);
         #1;
         chk(phase_o, {ph[2:0], ph[3]}, "phase order");
         chk(pmem_rd_o, ph[3], "fetch in first phase");
      end
   endtask : t_reset

   // Call, return, branch, taken skip and low-byte jump each cost a dummy cycle.
   task automatic t_trace();
      repeat (70) @(posedge clk_sys_i);
      for (int i = 0; i < 16; i++) begin
         chk(trace[i], exp_tr[i], "fetch sequence");
      end
   endtask : t_trace

   task automatic t_regs();
      apb(1'b0, OFS_ACC, 32'h0);
      chk(rd, 32'h40, "result register");
      apb(1'b1, OFS_ACC, 32'h99);
      apb(1'b0, OFS_ACC, 32'h0);
      chk(rd, 32'h40, "read-only write");
      apb(1'b0, 12'h010, 32'h0);
      chk(err, 1'b1, "unmapped error");
      chk(rd, 32'h0, "unmapped data");
      // This setup cycle falls in T4 of the loop's dummy cycle, where the counter is 0x41.
      apb(1'b0, OFS_PC_LOW, 32'h0);
      chk(rd, 32'h41, "low byte read");
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd[STAT_DEPTH_LSB +: 3], 3'h0, "depth after return");
      chk(rd[STAT_FLAGS_LSB +: 4], 4'h2, "add flags");
   endtask : t_regs

   // A full stack holds the request back until a return frees a level.
   task automatic t_defer();
      apb(1'b1, OFS_PC_LOW, 32'h60);
      repeat (100) @(posedge clk_sys_i);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd[STAT_DEPTH_LSB +: 3], 3'h6, "depth six");
      apb(1'b1, OFS_CTRL, 32'h1);
      irq_req_i <= 1'b1;
      repeat (40) @(posedge clk_sys_i);
      irq_req_i <= 1'b0;
      chk(acks, 0, "ack on full stack");
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd[STAT_PEND_BIT], 1'b1, "request kept");
      apb(1'b1, OFS_PC_LOW, 32'h67);
      n = 0;
      while (irq_ack_o !== 1'b1 && n < 100) begin
         @(posedge clk_sys_i);
         n++;
      end
      chk(pmem_addr_o, IRQ_VECTOR, "vector at ack");
      repeat (40) @(posedge clk_sys_i);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd[STAT_DEPTH_LSB +: 3], 3'h5, "depth after exits");
      chk(rd[STAT_PEND_BIT], 1'b0, "pending cleared");
      chk(rd[STAT_IRQ_EN_BIT], 1'b1, "enable rearmed");
      chk(acks, 1, "one ack");
   endtask : t_defer

   task automatic t_overflow();
      apb(1'b1, OFS_PC_LOW, 32'h64);
      repeat (60) @(posedge clk_sys_i);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd[STAT_DEPTH_LSB +: 3], 3'h6, "depth on overflow");
   endtask : t_overflow

   task automatic summarize();
      if (num_errors == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : summarize

   // Main sequence.
   initial begin
      t_reset();
      t_trace();
      t_regs();
      t_defer();
      t_overflow();
      summarize();
   end

   // Watchdog, well beyond the roughly 400 cycles the sequence needs.
   initial begin
      repeat (3000) @(posedge clk_sys_i);
      num_errors++;
      summarize();
   end
endmodule : cps_sequencer_tb
